// file: core/qbc_regs.vh
`ifndef QBC_REGS_VH
`define QBC_REGS_VH

// ----
// Register map
// ----
`define QBC_ADDR_PRIMARY     32'h3400000C
`define QBC_ADDR_SECONDARY   32'h34000010
`define QBC_ADDR_STATUS      32'h34000014

`define QBC_PRIMARY_RESET    32'h00000000
`define QBC_SECONDARY_RESET  32'h00000000
`define QBC_SECONDARY_MASK   32'h0000FFFC

// ----
// Field positions (least significant bit of each field)
// ----
`define QBC_F_DUMMY_MODE     30
`define QBC_F_EXTRA_MODE     28
`define QBC_F_ADDR_MODE      26
`define QBC_F_INST_MODE      24
`define QBC_F_EXTRA_BYTE     16
`define QBC_F_WRAP_OPCODE    8
`define QBC_F_NORMAL_OPCODE  0

`define QBC_F_FORCE_DUMMY    15
`define QBC_F_MIN_IDLE       12
`define QBC_F_WRAP_WIDTH     10
`define QBC_F_WRAP_COUNT     8
`define QBC_F_WRAP_SELECT    7
`define QBC_F_DUMMY_COUNT    4
`define QBC_F_TRISTATE       3
`define QBC_F_EXTRA_EN       2

`define QBC_F_STAT_BUSY      0
`define QBC_F_STAT_LEVEL     4

// ----
// Counts and timing
// ----
`define QBC_FORCED_DUMMY     3'h3
`define QBC_CLK_NS           100
`define QBC_SCK_HALF_NS      200
`define QBC_SCK_HALF_CYC     ((`QBC_SCK_HALF_NS + `QBC_CLK_NS - 1) / `QBC_CLK_NS)
`define QBC_FIFO_WIDTH       8
`define QBC_FIFO_DEPTH       16

`endif

// file: core/qbc_tick.v
`default_nettype none

// ----------------------------------------------------------------------------
// Half-period enable for the serial clock
// ----------------------------------------------------------------------------
module qbc_tick #(
    parameter integer HALF = 2
) (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       run_in,
    output wire       tick_out
);
    reg  [7:0] cnt_q;

    // Held at zero while idle so every frame starts with a full half period.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 8'h00;
        end else if (!run_in || tick_out) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign tick_out = run_in && (cnt_q == HALF[7:0] - 8'h01);
endmodule

`default_nettype wire

// file: core/qbc_fifo.v
`default_nettype none

// ----------------------------------------------------------------------------
// Flip-flop FIFO with valid and ready on both sides
// ----------------------------------------------------------------------------
module qbc_fifo #(
    parameter integer WIDTH = 8,
    parameter integer DEPTH = 16,
    parameter integer AW    = 4
) (
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] in_data_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    output wire [WIDTH-1:0] out_data_out,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [AW:0]      level_out
);
    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW:0]      wr_q;
    reg  [AW:0]      rd_q;
    wire             push;
    wire             pop;

    assign level_out     = wr_q - rd_q;
    assign in_ready_out  = (level_out != DEPTH[AW:0]);
    assign out_valid_out = (wr_q != rd_q);
    assign out_data_out  = mem_q[rd_q[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// file: core/qbc_burst.v
// Notes on behaviour
// - Dummy phase uses its lane mode field
// - Extra-byte phase uses its lane mode field
// - Address phase uses its lane mode field
// - Instruction phase uses its lane mode field
// - Enabled extra byte follows the address
// - Matching wrap burst sends the wrap opcode
// - Incremental and single reads send normal opcode
// - Wrap select off means normal opcode always
// - Force bit gives exactly three dummy bytes
// - Chip select idles high at least minimum cycles
// - Dummy count codes: none, one, two, four
// - Extra byte omitted when its enable is clear
// - Low nibble of extra byte released optionally
//
// The address-and-strobe port was left to the implementer.
`include "qbc_regs.vh"
`default_nettype none

module qbc_burst (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [31:0] bus_addr_in,
    input  wire [31:0] bus_wdata_in,
    input  wire        bus_wr_in,
    input  wire        bus_rd_in,
    output wire [31:0] bus_rdata_out,
    input  wire        req_valid_in,
    output wire        req_ready_out,
    input  wire [23:0] req_addr_in,
    input  wire [4:0]  req_len_in,
    input  wire        req_wrap_in,
    input  wire [1:0]  req_wrap_len_in,
    input  wire [1:0]  req_wrap_size_in,
    output wire [7:0]  rd_data_out,
    output wire        rd_valid_out,
    input  wire        rd_ready_in,
    output wire        flash_sck_out,
    output wire        flash_cs_n_out,
    output wire [3:0]  flash_io_out,
    output wire [3:0]  flash_io_oe_out,
    input  wire [3:0]  flash_io_in
);
    // ----
    // States
    // ----
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_INST  = 3'h1;
    localparam [2:0] ST_ADDR  = 3'h2;
    localparam [2:0] ST_EXTRA = 3'h3;
    localparam [2:0] ST_DUMMY = 3'h4;
    localparam [2:0] ST_DATA  = 3'h5;
    localparam [2:0] ST_GAP   = 3'h6;

    reg  [31:0] cfg_a_q;
    reg  [31:0] cfg_b_q;
    reg  [31:0] rdata_q;
    reg  [2:0]  state_q;
    reg  [31:0] sh_q;
    reg  [23:0] addr_q;
    reg  [8:0]  cnt_q;
    reg  [7:0]  rx_q;
    reg  [4:0]  len_q;
    reg  [3:0]  gap_q;
    reg         sck_q;
    reg         cs_n_q;
    reg  [3:0]  io_q;
    reg  [3:0]  oe_q;
    reg  [3:0]  sync1_q;
    reg  [3:0]  sync2_q;

    wire        tick;
    wire        fifo_ready;
    wire [4:0]  fifo_level;
    wire        active;
    wire        stall;
    wire        run;

    // ----
    // Configuration fields
    // ----
    wire [1:0]  dummy_phase_lane_mode       = cfg_a_q[`QBC_F_DUMMY_MODE +: 2];
    wire [1:0]  extra_phase_lane_mode       = cfg_a_q[`QBC_F_EXTRA_MODE +: 2];
    wire [1:0]  address_phase_lane_mode     = cfg_a_q[`QBC_F_ADDR_MODE +: 2];
    wire [1:0]  instruction_phase_lane_mode = cfg_a_q[`QBC_F_INST_MODE +: 2];
    wire [7:0]  extra_mode_byte_value       = cfg_a_q[`QBC_F_EXTRA_BYTE +: 8];
    wire [7:0]  wrapping_burst_opcode       = cfg_a_q[`QBC_F_WRAP_OPCODE +: 8];
    wire [7:0]  normal_read_opcode          = cfg_a_q[`QBC_F_NORMAL_OPCODE +: 8];
    wire        force_three_dummy           = cfg_b_q[`QBC_F_FORCE_DUMMY];
    wire [2:0]  min_select_idle_cycles      = cfg_b_q[`QBC_F_MIN_IDLE +: 3];
    wire [1:0]  wrap_beat_width             = cfg_b_q[`QBC_F_WRAP_WIDTH +: 2];
    wire [1:0]  wrap_beat_count             = cfg_b_q[`QBC_F_WRAP_COUNT +: 2];
    wire        wrap_opcode_select          = cfg_b_q[`QBC_F_WRAP_SELECT];
    wire [1:0]  dummy_byte_count            = cfg_b_q[`QBC_F_DUMMY_COUNT +: 2];
    wire        extra_low_nibble_tristate   = cfg_b_q[`QBC_F_TRISTATE];
    wire        extra_mode_byte_enable      = cfg_b_q[`QBC_F_EXTRA_EN];

    // ----
    // Register port
    // ----
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_a_q <= `QBC_PRIMARY_RESET;
            cfg_b_q <= `QBC_SECONDARY_RESET;
        end else if (bus_wr_in) begin
            if (bus_addr_in == `QBC_ADDR_PRIMARY) begin
                cfg_a_q <= bus_wdata_in;
            end
            if (bus_addr_in == `QBC_ADDR_SECONDARY) begin
                cfg_b_q <= bus_wdata_in & `QBC_SECONDARY_MASK;
            end
        end
    end

    // Read data stands for exactly one cycle; unmapped addresses read zero.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 32'h00000000;
        end else if (bus_rd_in) begin
            case (bus_addr_in)
                `QBC_ADDR_PRIMARY: begin
                    rdata_q <= cfg_a_q;
                end
                `QBC_ADDR_SECONDARY: begin
                    rdata_q <= cfg_b_q;
                end
                `QBC_ADDR_STATUS: begin
                    rdata_q <= {23'h000000, fifo_level, 3'h0, active || state_q == ST_GAP};
                end
                default: begin
                    rdata_q <= 32'h00000000;
                end
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign bus_rdata_out = rdata_q;

    // ----
    // Opcode choice, dummy count and per-phase loads
    // ----
    wire wrap_match = wrap_opcode_select && req_wrap_in && (req_wrap_len_in == wrap_beat_count)
                      && (req_wrap_size_in == wrap_beat_width);
    wire [7:0] opcode = wrap_match ? wrapping_burst_opcode : normal_read_opcode;

    reg  [2:0] dummy_bytes;
    always @* begin
        if (force_three_dummy) begin
            dummy_bytes = `QBC_FORCED_DUMMY;
        end else begin
            case (dummy_byte_count)
                2'h0:    dummy_bytes = 3'h0;
                2'h1:    dummy_bytes = 3'h1;
                2'h2:    dummy_bytes = 3'h2;
                default: dummy_bytes = 3'h4;
            endcase
        end
    end

    // Reserved lane code 3 falls back to one lane.
    function [1:0] lane_shift;
        input [1:0] mode;
        begin
            lane_shift = (mode == 2'h3) ? 2'h0 : mode;
        end
    endfunction

    reg  [1:0] cur_shift;
    always @* begin
        case (state_q)
            ST_INST:  cur_shift = lane_shift(instruction_phase_lane_mode);
            ST_ADDR:  cur_shift = lane_shift(address_phase_lane_mode);
            ST_EXTRA: cur_shift = lane_shift(extra_phase_lane_mode);
            ST_DUMMY: cur_shift = lane_shift(dummy_phase_lane_mode);
            ST_DATA:  cur_shift = lane_shift(address_phase_lane_mode);
            default:  cur_shift = 2'h0;
        endcase
    end

    // Phase that follows the current one, with its shift data, bit count and lane shift.
    reg  [2:0]  nxt_state;
    reg  [31:0] nxt_sh;
    reg  [8:0]  nxt_bits;
    reg  [1:0]  nxt_shift;
    always @* begin
        nxt_state = ST_GAP;
        nxt_sh    = 32'h00000000;
        nxt_bits  = 9'h008;
        nxt_shift = 2'h0;
        if (state_q == ST_IDLE) begin
            nxt_state = ST_INST;
        end else if (state_q == ST_INST) begin
            nxt_state = ST_ADDR;
        end else if (state_q == ST_ADDR && extra_mode_byte_enable) begin
            nxt_state = ST_EXTRA;
        end else if ((state_q == ST_ADDR || state_q == ST_EXTRA) && dummy_bytes != 3'h0) begin
            nxt_state = ST_DUMMY;
        end else if (state_q != ST_DATA) begin
            nxt_state = ST_DATA;
        end
        case (nxt_state)
            ST_INST: begin
                nxt_sh    = {opcode, 24'h000000};
                nxt_shift = lane_shift(instruction_phase_lane_mode);
            end
            ST_ADDR: begin
                nxt_sh    = {addr_q, 8'h00};
                nxt_bits  = 9'h018;
                nxt_shift = lane_shift(address_phase_lane_mode);
            end
            ST_EXTRA: begin
                nxt_sh    = {extra_mode_byte_value, 24'h000000};
                nxt_shift = lane_shift(extra_phase_lane_mode);
            end
            ST_DUMMY: begin
                nxt_bits  = {3'h0, dummy_bytes, 3'h0};
                nxt_shift = lane_shift(dummy_phase_lane_mode);
            end
            ST_DATA: begin
                nxt_bits  = {1'b0, len_q, 3'h0} + 9'h008;
                nxt_shift = lane_shift(address_phase_lane_mode);
            end
            default: begin
                nxt_bits  = 9'h008;
            end
        endcase
    end

    // ----
    // Sequencer
    // ----
    wire [8:0]  load_cnt     = (nxt_bits >> nxt_shift) - 9'h001;
    wire [2:0]  cyc_per_byte = 3'h7 >> cur_shift;
    wire        byte_done    = (cnt_q[2:0] & cyc_per_byte) == 3'h0;
    reg  [7:0]  rx_next;

    always @* begin
        case (cur_shift)
            2'h1:    rx_next = {rx_q[5:0], sync2_q[1:0]};
            2'h2:    rx_next = {rx_q[3:0], sync2_q};
            default: rx_next = {rx_q[6:0], sync2_q[1]};
        endcase
    end

    assign active        = (state_q != ST_IDLE) && (state_q != ST_GAP);
    // A full FIFO holds the clock low before a data cycle, so no byte is lost.
    assign stall         = (state_q == ST_DATA) && !sck_q && !fifo_ready;
    assign run           = (active && !stall) || (state_q == ST_GAP);
    assign req_ready_out = (state_q == ST_IDLE);

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            sh_q    <= 32'h00000000;
            cnt_q   <= 9'h000;
            rx_q    <= 8'h00;
            len_q   <= 5'h00;
            addr_q  <= 24'h000000;
            gap_q   <= 4'h0;
            sck_q   <= 1'b0;
            cs_n_q  <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            if (req_valid_in) begin
                addr_q  <= req_addr_in;
                len_q   <= req_len_in;
                sh_q    <= nxt_sh;
                cnt_q   <= load_cnt;
                cs_n_q  <= 1'b0;
                state_q <= ST_INST;
            end
        end else if (state_q == ST_GAP) begin
            if (tick) begin
                if (gap_q == 4'h0) begin
                    state_q <= ST_IDLE;
                end else begin
                    gap_q <= gap_q - 4'h1;
                end
            end
        end else if (tick) begin
            if (!sck_q) begin
                sck_q <= 1'b1;
            end else begin
                sck_q <= 1'b0;
                sh_q  <= sh_q << (3'h1 << cur_shift);
                if (state_q == ST_DATA) begin
                    rx_q <= rx_next;
                end
                if (cnt_q != 9'h000) begin
                    cnt_q <= cnt_q - 9'h001;
                end else begin
                    state_q <= nxt_state;
                    sh_q    <= nxt_sh;
                    cnt_q   <= load_cnt;
                    if (nxt_state == ST_GAP) begin
                        cs_n_q <= 1'b1;
                        gap_q  <= {min_select_idle_cycles, 1'b0};
                    end
                end
            end
        end
    end

    // ----
    // Pin drive and input synchroniser
    // ----
    wire [9:0] rem_bits = {1'b0, cnt_q + 9'h001} << cur_shift;
    wire       nib_off  = (state_q == ST_EXTRA) && extra_low_nibble_tristate
                          && (rem_bits <= 10'h004);
    reg  [3:0] io_d;
    reg  [3:0] oe_d;

    always @* begin
        io_d = 4'h0;
        oe_d = 4'h0;
        if (active && state_q != ST_DATA && !nib_off) begin
            case (cur_shift)
                2'h1: begin
                    io_d = {2'h0, sh_q[31:30]};
                    oe_d = 4'h3;
                end
                2'h2: begin
                    io_d = sh_q[31:28];
                    oe_d = 4'hF;
                end
                default: begin
                    io_d = {3'h0, sh_q[31]};
                    oe_d = 4'h1;
                end
            endcase
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_q    <= 4'h0;
            oe_q    <= 4'h0;
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            io_q    <= io_d;
            oe_q    <= oe_d;
            sync1_q <= flash_io_in;
            sync2_q <= sync1_q;
        end
    end

    assign flash_sck_out   = sck_q;
    assign flash_cs_n_out  = cs_n_q;
    assign flash_io_out    = io_q;
    assign flash_io_oe_out = oe_q;

    // ----
    // Serial clock pacing and read buffer
    // ----
    qbc_tick #(
        .HALF (`QBC_SCK_HALF_CYC)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .run_in   (run),
        .tick_out (tick)
    );

    wire push = (state_q == ST_DATA) && tick && sck_q && byte_done;

    qbc_fifo #(
        .WIDTH (`QBC_FIFO_WIDTH),
        .DEPTH (`QBC_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_data_in    (rx_next),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .out_data_out  (rd_data_out),
        .out_valid_out (rd_valid_out),
        .out_ready_in  (rd_ready_in),
        .level_out     (fifo_level)
    );
endmodule

`default_nettype wire

// file: tb/qbc_burst_props.sv
`include "qbc_regs.vh"
`default_nettype none

// ----
// Burst port checker
// ----
module qbc_burst_props (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic        bus_wr_in,
    input wire logic        bus_rd_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic        req_valid_in,
    input wire logic        req_ready_out,
    input wire logic        flash_sck_out,
    input wire logic        flash_cs_n_out,
    input wire logic [3:0]  flash_io_out,
    input wire logic [3:0]  flash_io_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sec_q;
    logic [2:0]  gap_q;
    logic [5:0]  hi_q;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // Latched while selected: software may rewrite it during the gap.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_q <= 32'h00000000;
            gap_q <= 3'h0;
            hi_q  <= 6'h3F;
        end else begin
            if (bus_wr_in && bus_addr_in == `QBC_ADDR_SECONDARY) sec_q <= bus_wdata_in;
            if (!flash_cs_n_out) gap_q <= sec_q[14:12];
            if (!flash_cs_n_out) hi_q <= 6'h00;
            else if (hi_q != 6'h3F) hi_q <= hi_q + 6'h01;
        end
    end
    sequence s_take;
        req_valid_in && req_ready_out;
    endsequence
    sequence s_sck_high;
        flash_sck_out [*2] ##1 !flash_sck_out;
    endsequence
    a_take_selects: assert property (s_take |=> !flash_cs_n_out && !req_ready_out)
        else $error("take not honoured");
    a_idle_sck_low: assert property (flash_cs_n_out |-> !flash_sck_out)
        else $error("sck high while idle");
    a_idle_released: assert property (flash_cs_n_out |-> flash_io_oe_out == 4'h0)
        else $error("lanes driven while deselected");
    a_ready_idle: assert property (req_ready_out |-> flash_cs_n_out)
        else $error("ready while selected");
    a_gap_min: assert property ($fell(flash_cs_n_out) |-> hi_q >= 4 * gap_q)
        else $error("idle gap short");
    a_sck_high_two: assert property ($rose(flash_sck_out) |-> s_sck_high)
        else $error("sck high time");
    a_io_stable: assert property (flash_sck_out && $past(flash_sck_out) |->
        $stable(flash_io_out) && $stable(flash_io_oe_out))
        else $error("lanes moved, sck high");
    a_rdata_zero: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 32'h00000000)
        else $error("stray read data");
    a_sec_readback: assert property (bus_rd_in && bus_addr_in == `QBC_ADDR_SECONDARY |=>
        bus_rdata_out == (sec_q & `QBC_SECONDARY_MASK))
        else $error("secondary read back wrong");
endmodule

`default_nettype wire

// file: tb/qbc_flash_model.sv
`default_nettype none

// ----
// Serial flash stand-in
// ----
module qbc_flash_model (
    input  wire logic        sck_in,
    input  wire logic        cs_n_in,
    input  wire logic [3:0]  io_in,
    input  wire logic [3:0]  oe_in,
    input  wire logic [1:0]  lm_in,
    output var  logic [3:0]  io_out,
    output var  logic [7:0]  op_out,
    output var  logic [15:0] n_rise_out,
    output var  logic [15:0] n_z_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Deselected lanes show the inverse nibble, so a stale read cannot match.
    assign io_out = cs_n_in ? 4'h9 : 4'h6;
    always @(negedge cs_n_in) begin
        n_rise_out = 16'h0000;
        n_z_out = 16'h0000;
    end
    always @(posedge sck_in) begin
        if (!cs_n_in) begin
            if (n_rise_out < 16'(8 >> lm_in)) begin
                case (lm_in)
                    2'h1: op_out = {op_out[5:0], io_in[1:0]};
                    2'h2: op_out = {op_out[3:0], io_in};
                    default: op_out = {op_out[6:0], io_in[0]};
                endcase
            end
            if (oe_in == 4'h0) n_z_out = n_z_out + 16'h0001;
            n_rise_out = n_rise_out + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// file: tb/tb_qbc_burst.sv
`include "qbc_regs.vh"
`default_nettype none

module tb_qbc_burst;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] p;
        logic [15:0] s;
        logic        w;
        logic [3:0]  wl;
        logic [4:0]  ln;
        logic [7:0]  op;
        logic [15:0] nr;
        logic [15:0] nz;
    } qbc_row_t;
    // ----
    // Rows: registers, request, opcode, rises, rises with lanes released.
    // ----
    qbc_row_t rows [15] = '{
        '{32'h00A50003,16'h0000,1'b0,4'h0,5'h03,8'h03,16'h0040,16'h0020},
        '{32'hAAF000EB,16'h0014,1'b0,4'h0,5'h03,8'hEB,16'h0014,16'h0008},
        '{32'h550000BB,16'h0020,1'b0,4'h0,5'h03,8'hBB,16'h0028,16'h0010},
        '{32'h0000000B,16'h8030,1'b0,4'h0,5'h03,8'h0B,16'h0058,16'h0020},
        '{32'h0000000B,16'h0030,1'b0,4'h0,5'h03,8'h0B,16'h0060,16'h0020},
        '{32'h80000003,16'h0010,1'b0,4'h0,5'h03,8'h03,16'h0042,16'h0020},
        '{32'h10120003,16'h0004,1'b0,4'h0,5'h03,8'h03,16'h0044,16'h0020},
        '{32'h04000003,16'h0000,1'b0,4'h0,5'h03,8'h03,16'h0024,16'h0010},
        '{32'hCC000003,16'h0010,1'b0,4'h0,5'h03,8'h03,16'h0048,16'h0020},
        '{32'h00000C03,16'h0980,1'b1,4'h6,5'h03,8'h0C,16'h0040,16'h0020},
        '{32'h00000C03,16'h0980,1'b1,4'h2,5'h03,8'h03,16'h0040,16'h0020},
        '{32'h00000C03,16'h0900,1'b1,4'h6,5'h03,8'h03,16'h0040,16'h0020},
        '{32'h00000C03,16'h0980,1'b0,4'h6,5'h03,8'h03,16'h0040,16'h0020},
        '{32'h00000003,16'h000C,1'b0,4'h0,5'h00,8'h03,16'h0030,16'h000C},
        '{32'h00000003,16'h7000,1'b0,4'h0,5'h1F,8'h03,16'h0120,16'h0100}
    };
    logic        clk_in, rst_in, bus_wr_in, bus_rd_in, req_valid_in, req_ready_out;
    logic        req_wrap_in, rd_valid_out, rd_ready_in, flash_sck_out, flash_cs_n_out;
    logic [31:0] bus_addr_in, bus_wdata_in, bus_rdata_out, v;
    logic [23:0] req_addr_in;
    logic [15:0] n_rise, n_z;
    logic [7:0]  rd_data_out, op, exp_db;
    logic [4:0]  req_len_in;
    logic [3:0]  flash_io_out, flash_io_oe_out, flash_io_in;
    logic [1:0]  req_wrap_len_in, req_wrap_size_in, inst_lm;
    int          n_mismatch, n_tests, n_pop, cyc, k, i;

    qbc_burst qbc_burst_i (.*);
    qbc_flash_model qbc_flash_model_i (
        .sck_in     (flash_sck_out),
        .cs_n_in    (flash_cs_n_out),
        .io_in      (flash_io_out),
        .oe_in      (flash_io_oe_out),
        .lm_in      (inst_lm),
        .io_out     (flash_io_in),
        .op_out     (op),
        .n_rise_out (n_rise),
        .n_z_out    (n_z)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus_wr_in <= 1'b1;
        bus_addr_in <= a;
        bus_wdata_in <= d;
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_in);
        bus_rd_in <= 1'b1;
        bus_addr_in <= a;
        @(posedge clk_in);
        bus_rd_in <= 1'b0;
        @(negedge clk_in);
        d = bus_rdata_out;
    endtask
    task automatic start(input logic w, input logic [3:0] wl, input logic [4:0] ln);
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_wrap_in <= w;
        {req_wrap_len_in, req_wrap_size_in} <= wl;
        req_len_in <= ln;
        do @(negedge clk_in); while (req_ready_out !== 1'b1);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
    endtask
    task automatic wait_idle();
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while ((req_ready_out !== 1'b1 || rd_valid_out !== 1'b0) && k < 3000);
        chk("burst end", 32'h1, {31'h0, req_ready_out});
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    always @(negedge clk_in) begin
        if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) begin
            n_pop++;
            chk("read byte", {24'h0, exp_db}, {24'h0, rd_data_out});
        end
    end

    initial begin
        {rst_in, bus_wr_in, bus_rd_in, req_valid_in, req_wrap_in, rd_ready_in} = 6'h21;
        {bus_addr_in, bus_wdata_in, req_len_in, req_wrap_len_in, req_wrap_size_in} = '0;
        req_addr_in = 24'h012345;
        inst_lm = 2'h0;
        exp_db = 8'hFF;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(`QBC_ADDR_PRIMARY, v);
        chk("primary reset", `QBC_PRIMARY_RESET, v);
        for (i = 0; i < 15; i++) begin
            wr(`QBC_ADDR_PRIMARY, rows[i].p);
            wr(`QBC_ADDR_SECONDARY, {16'h0, rows[i].s});
            rd(`QBC_ADDR_PRIMARY, v);
            chk("primary", rows[i].p, v);
            rd(`QBC_ADDR_SECONDARY, v);
            chk("secondary", {16'h0, rows[i].s}, v);
            inst_lm = rows[i].p[25:24];
            exp_db = rows[i].p[27:26] == 2'h2 ? 8'h66 : rows[i].p[27:26] == 2'h1 ? 8'hAA : 8'hFF;
            n_pop = 0;
            start(rows[i].w, rows[i].wl, rows[i].ln);
            wait_idle();
            chk("opcode", {24'h0, rows[i].op}, {24'h0, op});
            chk("rises", {16'h0, rows[i].nr}, {16'h0, n_rise});
            chk("released", {16'h0, rows[i].nz}, {16'h0, n_z});
            chk("bytes", 32'(rows[i].ln) + 32'h1, n_pop);
        end
        @(posedge clk_in);
        rd_ready_in <= 1'b0;
        n_pop = 0;
        start(1'b0, 4'h0, 5'h1F);
        k = 0;
        do begin
            rd(`QBC_ADDR_STATUS, v);
            k++;
        end while (v[8:4] !== 5'h10 && k < 500);
        chk("status full", 32'h00000101, v);
        v = {16'h0, n_rise};
        repeat (40) @(negedge clk_in);
        chk("stalled clock", v, {16'h0, n_rise});
        @(posedge clk_in);
        rd_ready_in <= 1'b1;
        wait_idle();
        chk("bytes", 32'h20, n_pop);
        chk("rises", 32'h120, {16'h0, n_rise});
        wr(32'h34000018, 32'hFFFFFFFF);
        rd(32'h34000018, v);
        chk("unmapped", 32'h0, v);
        rd(`QBC_ADDR_PRIMARY, v);
        chk("primary kept", 32'h00000003, v);
        wr(`QBC_ADDR_SECONDARY, 32'hFFFFFFFF);
        rd(`QBC_ADDR_SECONDARY, v);
        chk("secondary mask", `QBC_SECONDARY_MASK, v);
        start(1'b0, 4'h0, 5'h03);
        repeat (30) @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        chk("select after reset", 32'h1, {31'h0, flash_cs_n_out});
        chk("lanes after reset", 32'h0, {28'h0, flash_io_oe_out});
        rd(`QBC_ADDR_SECONDARY, v);
        chk("secondary reset", `QBC_SECONDARY_RESET, v);
        final_report();
    end
endmodule

bind qbc_burst qbc_burst_props qbc_burst_props_i (.*);

`default_nettype wire
